// *** logic/epw_core.sv ***
// Enhanced PWM core: base timer, duty shadow, steering, plain channel.
// Assumes all inputs synchronous to i_clk; i_ce low means sleep.
`timescale 1ns/1ps
`include "epw_cfg.svh"
module epw_core
	import epw_pkg::*;
#(
	parameter int PINS = 4,
	parameter int DB_W = 7
)(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_timer_run,
	input wire logic [1:0] i_timer_prescale_select,
	input wire logic [7:0] i_period_register,
	input wire logic [3:0] i_polarity_select_bits,
	input wire logic [1:0] i_output_config_field,
	input wire logic [7:0] i_duty_high_byte,
	input wire logic [1:0] i_duty_low_bits,
	input wire logic [DB_W-1:0] i_deadband_delay,
	input wire logic [3:0] i_steer,
	input wire logic [3:0] i_pin_direction,
	input wire logic i_ch2_enable,
	input wire logic [9:0] i_ch2_duty,
	input wire logic i_ch2_pin_direction,
	output logic [3:0] o_out,
	output logic [3:0] o_out_oe,
	output logic o_ch2_out,
	output logic o_ch2_oe,
	output logic [7:0] o_base_timer_count,
	output logic o_timer_match_flag,
	output logic [9:0] o_duty_shadow
);
	if (PINS != 4 || DB_W != 7) begin : g_bad_params
		$error("epw_core: only four pins and a 7-bit delay are served");
	end

	logic [7:0] tmr_q, tmr_d;
	logic [5:0] sub_q, sub_d, sub_last;
	logic [9:0] shadow_q, shadow_d, ch2_shadow_q, ch2_shadow_d;
	logic match_q, match_d;
	logic [1:0] fine;
	logic [9:0] tb;
	logic wrap;

	// Timer: 2-bit fine count plus 8-bit count forms the 10-bit base
	always_comb begin
		case (i_timer_prescale_select)
			`EPW_PS_1: sub_last = `EPW_SUB_LAST_1;
			`EPW_PS_4: sub_last = `EPW_SUB_LAST_4;
			default: sub_last = `EPW_SUB_LAST_16;
		endcase
		case (i_timer_prescale_select)
			`EPW_PS_1: fine = sub_q[1:0];
			`EPW_PS_4: fine = sub_q[3:2];
			default: fine = sub_q[5:4];
		endcase
		tb = {tmr_q, fine};
		// A prescale cut mid-count must not strand sub above its top
		wrap = i_timer_run && (sub_q >= sub_last) &&
			(tmr_q == i_period_register);
		sub_d = sub_q;
		tmr_d = tmr_q;
		shadow_d = shadow_q;
		ch2_shadow_d = ch2_shadow_q;
		match_d = 1'b0;
		if (i_timer_run) begin
			if (sub_q >= sub_last) begin
				sub_d = `EPW_SUB_RST;
				if (tmr_q == i_period_register) begin
					tmr_d = `EPW_TMR_RST;
					shadow_d = {i_duty_high_byte, i_duty_low_bits};
					ch2_shadow_d = i_ch2_duty;
					match_d = 1'b1;
				end else begin
					tmr_d = 8'(tmr_q + 8'h01);
				end
			end else begin
				sub_d = 6'(sub_q + 6'h01);
			end
		end
	end

	// Sleep simply holds every register, so wake resumes in place
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tmr_q <= `EPW_TMR_RST;
			sub_q <= `EPW_SUB_RST;
			shadow_q <= `EPW_DUTY_RST;
			ch2_shadow_q <= `EPW_DUTY_RST;
			match_q <= 1'b0;
		end else if (i_ce) begin
			tmr_q <= tmr_d;
			sub_q <= sub_d;
			shadow_q <= shadow_d;
			ch2_shadow_q <= ch2_shadow_d;
			match_q <= match_d;
		end
	end

	// Duty above the period keeps the compare true: pin stays put
	logic raw, ch2_raw, pwm_on;
	assign raw = tb < shadow_q;
	assign ch2_raw = tb < ch2_shadow_q;
	assign pwm_on = i_polarity_select_bits[3:2] == `EPW_PWM_ON;

	epw_arm_t arm_q, arm_d;
	logic ch2_arm_q, ch2_arm_d;

	always_comb begin
		arm_d = arm_q;
		case (arm_q)
			epw_idle: if (pwm_on) arm_d = epw_wait;
			epw_wait: begin
				if (!pwm_on)
					arm_d = epw_idle;
				else if (wrap)
					arm_d = epw_run;
			end
			epw_run: if (!pwm_on) arm_d = epw_idle;
			default: arm_d = epw_idle;
		endcase
		ch2_arm_d = i_ch2_enable & (ch2_arm_q | wrap);
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			arm_q <= epw_idle;
			ch2_arm_q <= 1'b0;
		end else if (i_ce) begin
			arm_q <= arm_d;
			ch2_arm_q <= ch2_arm_d;
		end
	end

	// Dead band counts clocks since the last raw edge, 4 per cycle
	logic raw_q, raw_d;
	logic [8:0] edge_q, edge_d, elapsed, dly;
	logic db_ok;

	always_comb begin
		raw_d = raw;
		elapsed = (raw != raw_q) ? `EPW_EDGE_RST : edge_q;
		edge_d = (elapsed == `EPW_EDGE_MAX) ? elapsed :
			9'(elapsed + 9'h001);
		dly = {i_deadband_delay, 2'b00};
		db_ok = elapsed >= dly;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			raw_q <= 1'b0;
			edge_q <= `EPW_EDGE_RST;
		end else if (i_ce) begin
			raw_q <= raw_d;
			edge_q <= edge_d;
		end
	end

	// Steering: pin order is {d, c, b, a}
	epw_cfg_t cfg;
	logic [3:0] act, own, inv;

	always_comb begin
		cfg = epw_cfg_t'(i_output_config_field);
		act = 4'h0;
		own = `EPW_PINS_NONE;
		case (cfg)
			epw_single: begin
				act = {4{raw}} & i_steer;
				own = i_steer;
			end
			epw_half: begin
				act = {2'b00, ~raw & db_ok, raw & db_ok};
				own = `EPW_PINS_HALF;
			end
			epw_fwd: begin
				act = {raw, 1'b0, 1'b0, 1'b1};
				own = `EPW_PINS_FULL;
			end
			epw_rev: begin
				act = {1'b0, 1'b1, raw, 1'b0};
				own = `EPW_PINS_FULL;
			end
			default: begin
				act = 4'h0;
				own = `EPW_PINS_NONE;
			end
		endcase
		if (!(pwm_on && arm_q == epw_run))
			own = `EPW_PINS_NONE;
		inv = {i_polarity_select_bits[0], i_polarity_select_bits[1],
			i_polarity_select_bits[0], i_polarity_select_bits[1]};
	end

	genvar gi;
	generate
		for (gi = 0; gi < PINS; gi++) begin : g_pin
			epw_pin u_pin (
				.i_clk(i_clk),
				.i_rst_n(i_rst_n),
				.i_ce(i_ce),
				.i_own(own[gi]),
				.i_active(act[gi]),
				.i_invert(inv[gi]),
				.i_dir_in(i_pin_direction[gi]),
				.o_level(o_out[gi]),
				.o_oe(o_out_oe[gi])
			);
		end
	endgenerate

	// Second channel: one pin, active-high, no steering
	epw_pin u_ch2 (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_own(ch2_arm_q),
		.i_active(ch2_raw),
		.i_invert(1'b0),
		.i_dir_in(i_ch2_pin_direction),
		.o_level(o_ch2_out),
		.o_oe(o_ch2_oe)
	);

	assign o_base_timer_count = tmr_q;
	assign o_timer_match_flag = match_q;
	assign o_duty_shadow = shadow_q;

	chk_shadow_latch: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(wrap && i_ce) |=> o_duty_shadow ==
			$past({i_duty_high_byte, i_duty_low_bits}) && o_timer_match_flag)
		else $error("duty shadow not loaded at period end");

	chk_shadow_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!wrap |=> $stable(o_duty_shadow))
		else $error("duty shadow changed inside a period");

	chk_sleep_freeze: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!i_ce |=> $stable(tmr_q) && $stable(sub_q) && $stable(arm_q))
		else $error("timer state moved during sleep");

	chk_sleep_pins: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!i_ce |=> $stable(o_out) && $stable(o_out_oe))
		else $error("pin drive moved during sleep");

	chk_timer_step: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && i_timer_run && sub_q >= sub_last &&
			tmr_q != i_period_register) |=> tmr_q == 8'($past(tmr_q) + 8'h01))
		else $error("base timer did not step at prescale end");

	chk_wait_start: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && arm_q != epw_run) |=> o_out_oe == `EPW_PINS_NONE)
		else $error("pins driven before a new period");

	chk_release_all: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && i_polarity_select_bits == `EPW_CTRL_OFF) ##1 i_ce
			|=> o_out_oe == `EPW_PINS_NONE)
		else $error("pins kept after control cleared");

	chk_half_unused: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && cfg == epw_half) |=> o_out_oe[3:2] == 2'b00)
		else $error("half-bridge drove c or d");

	chk_fwd_levels: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && pwm_on && arm_q == epw_run && cfg == epw_fwd)
			|=> o_out[0] == ~$past(i_polarity_select_bits[1]) &&
			o_out[2] == $past(i_polarity_select_bits[1]))
		else $error("forward bridge levels wrong");

	chk_dead_band: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && pwm_on && arm_q == epw_run && cfg == epw_half && !db_ok)
			|=> o_out[1:0] == {$past(i_polarity_select_bits[0]),
			$past(i_polarity_select_bits[1])})
		else $error("half-bridge active inside dead band");

	// Both half-bridge switches on at once would short the supply
	chk_half_pair: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && pwm_on && arm_q == epw_run && cfg == epw_half)
			|=> !((o_out[0] ^ $past(i_polarity_select_bits[1])) &&
			(o_out[1] ^ $past(i_polarity_select_bits[0]))))
		else $error("half-bridge outputs active together");

	chk_rev_levels: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && pwm_on && arm_q == epw_run && cfg == epw_rev)
			|=> o_out[2] == ~$past(i_polarity_select_bits[1]) &&
			o_out[0] == $past(i_polarity_select_bits[1]))
		else $error("reverse bridge levels wrong");

	chk_dir_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce |=> (o_out_oe & $past(i_pin_direction)) == `EPW_PINS_NONE)
		else $error("pin driven while its direction is input");

	chk_ch2_plain: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && !ch2_arm_q) |=> !o_ch2_oe)
		else $error("plain channel driven before arming");

	chk_match_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && !wrap) |=> !o_timer_match_flag)
		else $error("match flag raised away from period end");

	chk_timer_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && !i_timer_run) |=> $stable(tmr_q) && $stable(sub_q))
		else $error("base timer moved while stopped");
endmodule

// *** logic/epw_cfg.svh ***
// Constants for the enhanced PWM block with output steering.
// Assumes a single clock; included by the package and the core.
// Functional notes
// - Full ten-bit duty only at period 255
// - Resolution bits equal log2 of 4(period+1)
// - Overlong pulse width leaves pins unchanged
// - Base timer prescale of one, four, sixteen
// - Sleep stops timer and all block state
// - Driven pins hold their level in sleep
// - Timer resumes from held value on wake
// - Period time base taken from system clock
// - Reset clears state and makes pins inputs
// - Up to four outputs, ten-bit duty
// - Config 00 single, 10 half, 01/11 full
// - Half uses A,B; full uses all four
// - Second channel is plain single-pin PWM
// - Mode bits select active-high or active-low
// - Output withheld until a new period starts
// - Zero control word releases A-D, not the second channel pin
// - Unused pins are never driven
// - Forward: A on, D modulated; reverse mirrored
// - Half-bridge: A is PWM, B its complement
// - Half-bridge edge delay, seven-bit instruction count
// - Duty copied to shadow only at period end
`ifndef EPW_CFG_SVH
`define EPW_CFG_SVH
`define EPW_PS_1 2'b00
`define EPW_PS_4 2'b01
`define EPW_SUB_LAST_1 6'h03
`define EPW_SUB_LAST_4 6'h0f
`define EPW_SUB_LAST_16 6'h3f
`define EPW_PWM_ON 2'b11
`define EPW_TMR_RST 8'h00
`define EPW_SUB_RST 6'h00
`define EPW_DUTY_RST 10'h000
`define EPW_EDGE_RST 9'h000
`define EPW_EDGE_MAX 9'h1ff
`define EPW_CTRL_OFF 4'h0
`define EPW_PINS_HALF 4'h3
`define EPW_PINS_FULL 4'hf
`define EPW_PINS_NONE 4'h0
`endif

// *** logic/epw_pkg.sv ***
// Types shared by the enhanced PWM core and its pin stage.
// Assumes the constants header is available on the include path.
`include "epw_cfg.svh"
package epw_pkg;
	typedef enum logic [1:0] {
		epw_single = 2'b00,
		epw_fwd = 2'b01,
		epw_half = 2'b10,
		epw_rev = 2'b11
	} epw_cfg_t;
	typedef enum logic [1:0] {
		epw_idle = 2'b00,
		epw_wait = 2'b01,
		epw_run = 2'b11
	} epw_arm_t;
endpackage

// *** logic/epw_pin.sv ***
// One output pin stage: polarity, ownership and direction gating.
// Assumes i_active is the logical PWM level from the core.
`timescale 1ns/1ps
module epw_pin
	import epw_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_own,
	input wire logic i_active,
	input wire logic i_invert,
	input wire logic i_dir_in,
	output logic o_level,
	output logic o_oe
);
	logic level_q, level_d, oe_q, oe_d;

	always_comb begin
		oe_d = i_own & ~i_dir_in;
		level_d = i_own ? (i_active ^ i_invert) : 1'b0;
	end

	// Frozen while i_ce is low so a driven pin keeps its level
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			level_q <= 1'b0;
			oe_q <= 1'b0;
		end else if (i_ce) begin
			level_q <= level_d;
			oe_q <= oe_d;
		end
	end

	assign o_level = level_q;
	assign o_oe = oe_q;
endmodule

// *** test/epw_load.sv ***
// Power switch gate drivers hanging on the four steered pins.
// Assumes a pull-down on each gate input while the pin is released.
`timescale 1ns/1ps
module epw_load
	import epw_pkg::*;
(
	input wire logic [3:0] i_level,
	input wire logic [3:0] i_oe,
	output logic [3:0] o_gate
);
	// Released pin reads low so the switch stays off, not the stale level
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			o_gate[k] = i_oe[k] ? i_level[k] : 1'b0;
		end
	end
endmodule

// *** test/test_epw_core.sv ***
// Self-checking bench for the enhanced PWM core and its pin loads.
// Assumes one 25 MHz clock and inputs driven 1 ns after rising edges.
`timescale 1ns/1ps
module test_epw_core
	import epw_pkg::*;
();
	logic i_clk, i_rst_n, i_ce, i_timer_run, i_ch2_enable;
	logic i_ch2_pin_direction, o_ch2_out, o_ch2_oe, o_timer_match_flag;
	logic [1:0] i_timer_prescale_select, i_output_config_field;
	logic [1:0] i_duty_low_bits;
	logic [7:0] i_period_register, i_duty_high_byte, o_base_timer_count;
	logic [3:0] i_polarity_select_bits, i_steer, i_pin_direction;
	logic [3:0] o_out, o_out_oe, pin;
	logic [6:0] i_deadband_delay;
	logic [9:0] i_ch2_duty, o_duty_shadow;
	logic [31:0] seed;
	int n_errors, comparisons, m_tmr, m_sub, m_shd, m_mat;
	int lst[4] = '{3, 15, 63, 63};
	epw_core epw_core_i (.*);
	epw_load epw_load_i (.i_level(o_out), .i_oe(o_out_oe), .o_gate(pin));
	initial begin
		i_clk = 0;
		forever #20 i_clk = ~i_clk;
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task end_sim;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Timer model: sub step counter, then base count, shadow load at wrap
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			{m_tmr, m_sub, m_shd, m_mat} = '0;
		end else if (i_ce) begin
			m_mat = 0;
			if (i_timer_run && m_sub == lst[i_timer_prescale_select]) begin
				m_sub = 0;
				m_tmr = m_tmr == i_period_register ? 0 : m_tmr + 1;
				if (m_tmr == 0) begin
					m_mat = 1;
					m_shd = {i_duty_high_byte, i_duty_low_bits};
				end
			end else if (i_timer_run) begin
				m_sub++;
			end
		end
	end
	always @(negedge i_clk) begin
		if (i_rst_n) begin
			check(o_base_timer_count, m_tmr);
			check(o_timer_match_flag, m_mat);
			check(o_duty_shadow, m_shd);
		end
	end
	task wait_match(input bit z);
		int w;
		w = 0;
		do begin
			@(negedge i_clk);
			w++;
			if (z)
				check(o_out_oe, 0);
		end while (o_timer_match_flag !== 1'b1 && w < 5000);
		if (w >= 5000)
			check(0, 1);
	endtask
	task run(input int s, per, cfg, pol, stp, db, dir, d);
		int ps, P, pw, u, c2, d2, a[4], n[4];
		@(posedge i_clk);
		#1 i_rst_n = 0;
		ps = 1 << (2 * (s > 2 ? 2 : s));
		P = (per + 1) * 4 * ps;
		if (d < 0)
			d = xs() % (P / ps);
		d2 = xs() % (P / ps);
		pw = d * ps > P ? P : d * ps;
		i_timer_prescale_select = s[1:0];
		i_period_register = per[7:0];
		i_output_config_field = cfg[1:0];
		i_polarity_select_bits = pol[3:0];
		i_steer = stp[3:0];
		i_deadband_delay = db[6:0];
		i_pin_direction = dir[3:0];
		{i_duty_high_byte, i_duty_low_bits} = d[9:0];
		i_ch2_duty = d2[9:0];
		repeat (3) @(posedge i_clk);
		#1 check(o_out_oe, 0);
		check(o_duty_shadow, 0);
		check({o_out, o_ch2_out, o_ch2_oe}, 0);
		i_rst_n = 1;
		wait_match(1);
		wait_match(0);
		n = '{0, 0, 0, 0};
		c2 = 0;
		repeat (P) begin
			@(negedge i_clk);
			for (int k = 0; k < 4; k++)
				n[k] += pin[k];
			c2 += o_ch2_out;
		end
		a = '{pw, pw, pw, pw};
		if (cfg == 2)
			a = '{pw > 4 * db ? pw - 4 * db : 0,
				P - pw > 4 * db ? P - pw - 4 * db : 0, 0, 0};
		if (cfg == 1)
			a = '{P, 0, 0, pw};
		if (cfg == 3)
			a = '{0, pw, P, 0};
		u = cfg == 0 ? stp : cfg == 2 ? 3 : 15;
		if (pol < 12)
			u = 0;
		u &= ~dir;
		for (int k = 0; k < 4; k++) begin
			check(o_out_oe[k], u[k]);
			check(n[k], !u[k] ? 0 : pol[~k & 1] ? P - a[k] : a[k]);
		end
		check(c2, d2 * ps);
		check(o_ch2_oe, 1'b1);
	endtask
	// Duty rewritten mid-period, then a sleep with pins at a live level
	task nap;
		logic [7:0] q;
		@(posedge i_clk);
		#1 {i_duty_high_byte, i_duty_low_bits} = 10'(xs());
		repeat (5) @(posedge i_clk);
		#1 i_ce = 0;
		@(negedge i_clk);
		q = {o_out, o_out_oe};
		repeat (30) begin
			@(negedge i_clk);
			check({o_out, o_out_oe}, q);
		end
		@(posedge i_clk);
		#1 i_ce = 1;
		wait_match(0);
		wait_match(0);
		// Stopped timer must hold; model compares every cycle
		@(posedge i_clk);
		#1 {i_timer_run, i_ch2_enable} = 2'b00;
		repeat (20) @(negedge i_clk);
		check(o_ch2_oe, 1'b0);
		@(posedge i_clk);
		#1 {i_timer_run, i_ch2_enable} = 2'b11;
		wait_match(0);
	endtask
	initial begin
		repeat (40000) @(posedge i_clk);
		n_errors++;
		end_sim;
	end
	initial begin
		seed = 32'h856cec76;
		{n_errors, comparisons, i_rst_n, i_ch2_pin_direction} = '0;
		{i_ce, i_timer_run, i_ch2_enable} = 3'h7;
		{i_timer_prescale_select, i_output_config_field, i_duty_low_bits} = '0;
		{i_period_register, i_duty_high_byte, i_polarity_select_bits} = '0;
		{i_steer, i_pin_direction, i_deadband_delay, i_ch2_duty} = '0;
		run(0, 3, 0, 12, 15, 0, 0, -1);
		run(1, 3, 0, 12, 5, 0, 0, -1);
		run(2, 3, 2, 12, 0, 0, 0, -1);
		run(3, 3, 1, 12, 0, 0, 0, -1);
		run(0, 3, 3, 12, 0, 0, 0, -1);
		run(0, 3, 2, 12, 0, 1, 0, 10);
		run(0, 3, 2, 12, 0, 3, 0, 10);
		run(0, 3, 0, 14, 15, 0, 0, -1);
		run(0, 3, 1, 15, 0, 0, 0, -1);
		run(0, 3, 0, 0, 15, 0, 0, -1);
		run(0, 3, 0, 12, 15, 0, 6, -1);
		run(0, 3, 0, 12, 15, 0, 0, 20);
		run(0, 255, 0, 12, 1, 0, 0, 1023);
		run(0, 63, 0, 12, 1, 0, 0, 255);
		nap;
		end_sim;
	end
endmodule
